// ===== ifd_regs.svh
`ifndef IFD_REGS_SVH
`define IFD_REGS_SVH

// Register indices; the byte address is four times the index.
`define IFD_IDX_REF23 6'h11
`define IFD_IDX_REF45 6'h12
`define IFD_IDX_REF67 6'h13
`define IFD_IDX_SYNC01 6'h14
`define IFD_IDX_SYNC28 6'h15
`define IFD_IDX_LIMIT 6'h16
`define IFD_IDX_IRQ_STAT 6'h20
`define IFD_IDX_IRQ_MASK 6'h21

// Reset values.
`define IFD_LIMIT_RST 8'h33
`define IFD_IRQ_MASK_RST 14'h0000

// Field positions.
`define IFD_LO_POS 0
`define IFD_HI_POS 4
`define IFD_FAIL_LO_POS 3
`define IFD_FAIL_HI_POS 7

// Rate code sets.
`define IFD_REF_IDLE 4'hf
`define IFD_REF_LEGAL 16'h87ff
`define IFD_SYNC_IDLE 3'h6
`define IFD_SYNC_LEGAL 8'hbf

// Interrupt status layout.
`define IFD_IRQ_W 14
`define IFD_IRQ_REF_POS 0
`define IFD_IRQ_SYNC_POS 6
`define IFD_IRQ_FAIL_POS 10

`endif

// ===== ifd_pkg.sv
package ifd_pkg;

   // Offset limit choices of a three-bit select field.
   typedef enum logic [2:0] {
      IFD_LIM_9P2_12 = 3'h0,
      IFD_LIM_40_52 = 3'h1,
      IFD_LIM_100_130 = 3'h2,
      IFD_LIM_64_83 = 3'h3,
      IFD_LIM_13P8_18 = 3'h4,
      IFD_LIM_24P6_32 = 3'h5,
      IFD_LIM_36P6_47P5 = 3'h6,
      IFD_LIM_52_67P5 = 3'h7
   } ifd_limit_t;

   // Results offered by the measurement logic, index 0 is the lowest input.
   typedef struct packed {
      logic [3:0] sync_fail;
      logic [3:0] sync_valid;
      logic [11:0] sync_code;
      logic [5:0] ref_valid;
      logic [23:0] ref_code;
   } ifd_meas_t;

   // Limit selections for references zero and one.
   typedef struct packed {
      ifd_limit_t input_one_limit_select;
      ifd_limit_t input_zero_limit_select;
   } ifd_limits_t;

endpackage

// ===== ifd_rate_field.sv
`timescale 1ns/1ps
`default_nettype none
module ifd_rate_field #(
   parameter int W = 4,
   parameter logic [W-1:0] IDLE = '1,
   parameter logic [(1<<W)-1:0] LEGAL = '1
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Measurement side.
   input wire logic meas_valid,
   input wire logic [W-1:0] meas_code,
   // Register side.
   output logic [W-1:0] code_ff,
   output logic changed
);

   logic [W-1:0] nxt_code;
   logic legal;

   // A code outside the legal set, or no valid result, shows as not detected.
   assign legal = LEGAL[meas_code];
   assign nxt_code = (meas_valid && legal) ? meas_code : IDLE;
   assign changed = (nxt_code != code_ff);

   // The field holds its not-detected code from reset until a valid result.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         code_ff <= IDLE;
      end else begin
         code_ff <= nxt_code;
      end
   end

endmodule
`default_nettype wire

// ===== ifd_top.sv
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "ifd_regs.svh"
module ifd_top #(
   parameter int ADDR_W = 8,
   parameter int N_REF = 6,
   parameter int N_SYNC = 4
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Measurement results.
   input wire ifd_pkg::ifd_meas_t meas,
   // Limit selections and interrupt.
   output ifd_pkg::ifd_limits_t limits,
   output logic irq
);

   // Register state.
   logic [7:0] limit_ff;
   logic [7:0] nxt_limit;
   logic [`IFD_IRQ_W-1:0] irq_stat_ff;
   logic [`IFD_IRQ_W-1:0] nxt_irq_stat;
   logic [`IFD_IRQ_W-1:0] irq_mask_ff;
   logic [`IFD_IRQ_W-1:0] nxt_irq_mask;
   logic [31:0] prdata_ff;
   logic [31:0] nxt_prdata;
   logic [N_SYNC-1:0] fail_ff;
   logic [N_SYNC-1:0] nxt_fail;

   // Filtered fields and their change events.
   logic [3:0] ref_rate [N_REF];
   logic [2:0] sync_rate [N_SYNC];
   logic [N_REF-1:0] ref_chg;
   logic [N_SYNC-1:0] sync_chg;
   logic [N_SYNC-1:0] fail_rise;

   // Decoded bus signals.
   logic [ADDR_W-3:0] idx;
   logic aligned;
   logic setup_ph;
   logic access_ph;
   logic wr_acc;
   logic rd_acc;
   logic lane0;
   logic hit_ref23;
   logic hit_ref45;
   logic hit_ref67;
   logic hit_sync01;
   logic hit_sync28;
   logic hit_limit;
   logic hit_stat;
   logic hit_mask;
   logic mapped;

   // Register images as read back.
   logic [7:0] ref23_img;
   logic [7:0] ref45_img;
   logic [7:0] ref67_img;
   logic [7:0] sync01_img;
   logic [7:0] sync28_img;
   logic [7:0] limit_img;
   logic [`IFD_IRQ_W-1:0] irq_set;
   logic [`IFD_IRQ_W-1:0] irq_clr;
   logic [31:0] rd_mux;

   // One filter per reference input, legal codes and the idle code only.
   genvar gr;
   generate
      for (gr = 0; gr < N_REF; gr++) begin : g_ref
         ifd_rate_field #(
            .W(4),
            .IDLE(`IFD_REF_IDLE),
            .LEGAL(`IFD_REF_LEGAL)
         ) u_field (
            .pclk(pclk),
            .presetn(presetn),
            .meas_valid(meas.ref_valid[gr]),
            .meas_code(meas.ref_code[gr*4 +: 4]),
            .code_ff(ref_rate[gr]),
            .changed(ref_chg[gr])
         );
      end
   endgenerate

   // One filter per sync input; an unlisted code reads as not detected.
   genvar gs;
   generate
      for (gs = 0; gs < N_SYNC; gs++) begin : g_sync
         ifd_rate_field #(
            .W(3),
            .IDLE(`IFD_SYNC_IDLE),
            .LEGAL(`IFD_SYNC_LEGAL)
         ) u_field (
            .pclk(pclk),
            .presetn(presetn),
            .meas_valid(meas.sync_valid[gs]),
            .meas_code(meas.sync_code[gs*3 +: 3]),
            .code_ff(sync_rate[gs]),
            .changed(sync_chg[gs])
         );
      end
   endgenerate

   // Sync failure flags follow the monitor and flag each new failure.
   assign nxt_fail = meas.sync_fail;
   assign fail_rise = nxt_fail & ~fail_ff;

   // The monitor sits on the bus clock, so the failure level needs no synchroniser.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fail_ff <= '0;
      end else begin
         fail_ff <= nxt_fail;
      end
   end

   // Address decode; the word index is the register index.
   assign idx = paddr[ADDR_W-1:2];
   assign aligned = (paddr[1:0] == 2'h0);
   assign setup_ph = psel && !penable;
   assign access_ph = psel && penable;
   assign wr_acc = access_ph && pwrite;
   assign rd_acc = access_ph && !pwrite;
   assign lane0 = pstrb[0];

   // Register hits.
   assign hit_ref23 = aligned && (idx == `IFD_IDX_REF23);
   assign hit_ref45 = aligned && (idx == `IFD_IDX_REF45);
   assign hit_ref67 = aligned && (idx == `IFD_IDX_REF67);
   assign hit_sync01 = aligned && (idx == `IFD_IDX_SYNC01);
   assign hit_sync28 = aligned && (idx == `IFD_IDX_SYNC28);
   assign hit_limit = aligned && (idx == `IFD_IDX_LIMIT);
   assign hit_stat = aligned && (idx == `IFD_IDX_IRQ_STAT);
   assign hit_mask = aligned && (idx == `IFD_IDX_IRQ_MASK);
   assign mapped = hit_ref23 | hit_ref45 | hit_ref67 | hit_sync01 | hit_sync28 |
                   hit_limit | hit_stat | hit_mask;

   // Zero wait states; an unmapped or misaligned address answers with an error.
   assign pready = 1'b1;
   assign pslverr = access_ph && !mapped;

   // Reference registers, even input low nibble and odd input high nibble.
   assign ref23_img = {ref_rate[1], ref_rate[0]};
   assign ref45_img = {ref_rate[3], ref_rate[2]};
   assign ref67_img = {ref_rate[5], ref_rate[4]};

   // Sync registers, rate codes with the failure flag above each.
   assign sync01_img = {fail_ff[1], sync_rate[1], fail_ff[0], sync_rate[0]};
   assign sync28_img = {fail_ff[3], sync_rate[3], fail_ff[2], sync_rate[2]};

   // Reserved limit bits always read as zero.
   assign limit_img = {1'b0, limit_ff[6:4], 1'b0, limit_ff[2:0]};

   // Read multiplexer, narrow registers in the low bits.
   assign rd_mux = hit_ref23 ? {24'h000000, ref23_img} :
                   hit_ref45 ? {24'h000000, ref45_img} :
                   hit_ref67 ? {24'h000000, ref67_img} :
                   hit_sync01 ? {24'h000000, sync01_img} :
                   hit_sync28 ? {24'h000000, sync28_img} :
                   hit_limit ? {24'h000000, limit_img} :
                   hit_stat ? {18'h00000, irq_stat_ff} :
                   hit_mask ? {18'h00000, irq_mask_ff} :
                   32'h00000000;

   // Read data is captured in the setup cycle and stands through the access.
   assign nxt_prdata = (setup_ph && !pwrite) ? rd_mux : prdata_ff;
   assign prdata = prdata_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h00000000;
      end else begin
         prdata_ff <= nxt_prdata;
      end
   end

   // Limit register; writes to detection registers fall through unused.
   assign nxt_limit = (wr_acc && hit_limit && lane0) ?
                      {1'b0, pwdata[6:4], 1'b0, pwdata[2:0]} : limit_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         limit_ff <= `IFD_LIMIT_RST;
      end else begin
         limit_ff <= nxt_limit;
      end
   end

   // Limit selects drive the out-of-range monitor of references zero and one.
   assign limits.input_zero_limit_select = ifd_pkg::ifd_limit_t'(limit_ff[2:0]);
   assign limits.input_one_limit_select = ifd_pkg::ifd_limit_t'(limit_ff[6:4]);

   // Interrupt events: rate changes and new sync failures.
   assign irq_set = {fail_rise, sync_chg, ref_chg};

   // A status read clears only the bits it returned, so an event in the setup cycle survives.
   assign irq_clr = (rd_acc && hit_stat) ? prdata_ff[`IFD_IRQ_W-1:0] : '0;
   assign nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_set;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_ff <= '0;
      end else begin
         irq_stat_ff <= nxt_irq_stat;
      end
   end

   // Interrupt mask register, same layout as status, one enables a bit.
   assign nxt_irq_mask = (wr_acc && hit_mask && lane0 && pstrb[1]) ? pwdata[`IFD_IRQ_W-1:0] :
                         irq_mask_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask_ff <= `IFD_IRQ_MASK_RST;
      end else begin
         irq_mask_ff <= nxt_irq_mask;
      end
   end

   // Level interrupt while any enabled status bit is set.
   assign irq = |(irq_stat_ff & irq_mask_ff);

endmodule
`default_nettype wire

// ===== ifd_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ifd_asserts #(
   parameter int ADDR_W = 8
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Bus and block outputs.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire ifd_pkg::ifd_meas_t meas,
   input wire ifd_pkg::ifd_limits_t limits
);
   // All properties share the bus clock and reset.
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Access and limit write decode.
   wire logic rd = psel && penable && !pwrite;
   wire logic lw = psel && penable && pwrite && paddr == 8'h58 && pstrb[0];
   a_limit_load: assert property (lw |=> limits == {$past(pwdata[6:4]), $past(pwdata[2:0])})
      else $error("limit not loaded");
   a_limit_hold: assert property (!lw |=> $stable(limits))
      else $error("limit changed");
   a_limit_read: assert property (rd && paddr == 8'h58 |-> prdata[7:0] == {1'b0, limits[5:3], 1'b0, limits[2:0]})
      else $error("limit read");
   a_ref_field: assert property (rd && paddr == 8'h44 |-> prdata[3:0] == (($past(meas.ref_valid[0], 2) &&
      $past(meas.ref_code[3:0], 2) < 4'hb) ? $past(meas.ref_code[3:0], 2) : 4'hf)) else $error("ref field");
   a_sync_code: assert property (rd && paddr == 8'h50 |-> prdata[6:4] ==
      ($past(meas.sync_valid[1], 2) ? $past(meas.sync_code[5:3], 2) : 3'h6)) else $error("sync code");
   a_fail_bits: assert property (rd && paddr == 8'h50 |-> {prdata[7], prdata[3]} == $past(meas.sync_fail[1:0], 2))
      else $error("fail bits");
   a_sync_idle: assert property (rd && paddr == 8'h54 && !$past(meas.sync_valid[2], 2) |-> prdata[2:0] == 3'h6)
      else $error("sync idle");
   a_upper_zero: assert property (rd && paddr inside {8'h44, 8'h48, 8'h4c, 8'h50, 8'h54} |-> !pslverr && prdata[31:8] == 0)
      else $error("upper bits");
endmodule
bind ifd_top ifd_asserts #(.ADDR_W(ADDR_W)) u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
   .prdata, .pslverr, .meas, .limits);
`default_nettype wire

// ===== ifd_meas_src.sv
`timescale 1ns/1ps
`default_nettype none
module ifd_meas_src (
   // Results handed to the register block.
   output var ifd_pkg::ifd_meas_t meas
);
   // Nothing is recognised until a source is set up.
   initial meas = '0;
   // Reference result, changed just after a rising edge.
   task automatic set_ref(input int i, input logic [3:0] c, input logic v);
      meas.ref_code[4*i +: 4] <= c;
      meas.ref_valid[i] <= v;
   endtask
   // Sync result and failure level.
   task automatic set_sync(input int i, input logic [2:0] c, input logic v, input logic f);
      meas.sync_code[3*i +: 3] <= c;
      meas.sync_valid[i] <= v;
      meas.sync_fail[i] <= f;
   endtask
endmodule
`default_nettype wire

// ===== test_input_freq_detect_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_input_freq_detect_status_regs;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hf;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   ifd_pkg::ifd_meas_t meas;
   ifd_pkg::ifd_limits_t limits;
   int n_errors = 0;
   int comparisons = 0;
   logic [31:0] rd;
   logic er;
   // The 50 MHz clock.
   always #10 pclk = ~pclk;
   ifd_meas_src src (.meas(meas));
   ifd_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
      .meas, .limits, .irq);
   // Verdict and end of run.
   task automatic test_done;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Compares a seen value with the expected one.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer; the wait for ready is bounded.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         n_errors++;
         test_done;
      end
      @(posedge pclk);
   endtask
   // Reads a register and compares it.
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   // Reset values; a write to a status register is ignored; unmapped read errs.
   task automatic t_reset;
      apb(1'b1, 8'h44, 32'h0);
      rdchk(8'h44, 32'hff);
      rdchk(8'h48, 32'hff);
      rdchk(8'h4c, 32'hff);
      rdchk(8'h50, 32'h66);
      rdchk(8'h54, 32'h66);
      rdchk(8'h58, 32'h33);
      chk({31'h0, er}, 32'h0);
      rdchk(8'h84, 32'h0);
      rdchk(8'h80, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk({31'h0, er}, 32'h1);
      apb(1'b0, 8'h45, 32'h0);
      chk({31'h0, er}, 32'h1);
   endtask
   // Each reference through every code, the others idle.
   task automatic t_ref;
      logic [3:0] e;
      for (int i = 0; i < 6; i++) begin
         for (int c = 0; c < 16; c++) begin
            src.set_ref(i, c[3:0], 1'b1);
            @(posedge pclk);
            e = (c < 11) ? c[3:0] : 4'hf;
            rdchk(8'h44 + 8'(4 * (i / 2)), (i % 2) ? {24'h0, e, 4'hf} : {24'h0, 4'hf, e});
         end
         src.set_ref(i, 4'h0, 1'b0);
      end
   endtask
   // Each sync input through every code with its failure level toggling.
   task automatic t_sync;
      logic [3:0] e;
      for (int j = 0; j < 4; j++) begin
         for (int c = 0; c < 8; c++) begin
            src.set_sync(j, c[2:0], 1'b1, c[0]);
            @(posedge pclk);
            e = {c[0], c[2:0]};
            rdchk(8'h50 + 8'(4 * (j / 2)), (j % 2) ? {24'h0, e, 4'h6} : {24'h0, 4'h6, e});
         end
         src.set_sync(j, 3'h0, 1'b0, 1'b0);
      end
   endtask
   // Every limit code in both fields, reserved bits kept at zero.
   task automatic t_limit;
      logic [7:0] v;
      for (int k = 0; k < 8; k++) begin
         v = {1'b0, k[2:0], 1'b0, 3'(7 - k)};
         apb(1'b1, 8'h58, {24'h0, v});
         chk({26'h0, limits}, {26'h0, v[6:4], v[2:0]});
         rdchk(8'h58, {24'h0, v});
      end
      // A write without the low byte lane leaves the limits alone.
      pstrb <= 4'he;
      apb(1'b1, 8'h58, 32'h33);
      pstrb <= 4'hf;
      rdchk(8'h58, 32'h70);
   endtask
   // A masked event keeps irq low; an unmasked one raises it until read.
   task automatic t_irq;
      apb(1'b0, 8'h80, 32'h0);
      apb(1'b1, 8'h84, 32'h0);
      src.set_ref(0, 4'h1, 1'b1);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      rdchk(8'h80, 32'h1);
      apb(1'b1, 8'h84, 32'h400);
      src.set_sync(0, 3'h2, 1'b1, 1'b1);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      rdchk(8'h80, 32'h440);
      chk({31'h0, irq}, 32'h0);
      // A mask write without both low byte lanes is ignored.
      pstrb <= 4'hd;
      apb(1'b1, 8'h84, 32'h0);
      pstrb <= 4'hf;
      rdchk(8'h84, 32'h400);
   endtask
   // Reset in mid-run restores the limits and the not-detected codes.
   task automatic t_rst_mid;
      apb(1'b1, 8'h58, 32'h11);
      src.set_ref(0, 4'h0, 1'b0);
      src.set_sync(0, 3'h0, 1'b0, 1'b0);
      src.set_ref(2, 4'h5, 1'b1);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk({26'h0, limits}, 32'h1b);
      chk({31'h0, irq}, 32'h0);
      presetn <= 1'b1;
      @(posedge pclk);
      rdchk(8'h58, 32'h33);
      rdchk(8'h48, 32'hf5);
      chk({31'h0, irq}, 32'h0);
      rdchk(8'h80, 32'h4);
   endtask
   // Reset for eight cycles, then every scenario in turn.
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset;
      t_ref;
      t_sync;
      t_limit;
      t_irq;
      t_rst_mid;
      test_done;
   end
endmodule
`default_nettype wire
